// File: shared/cscr_pkg.sv
package cscr_pkg;
   // Data word width of the mapped registers; the loop start high register holds only LOOP_HI_W bits
   localparam int DATA_W = 16;

   // Register context count and working register count
   localparam int CTX_NUM = 3;
   localparam int WREG_NUM = 16;
   localparam logic [3:0] WREG_STACK_IDX = 4'hF;

   // Data space byte addresses of the mapped registers
   localparam logic [15:0] ADDR_WREG_BASE = 16'h0000;
   localparam logic [15:0] ADDR_WREG_LAST = 16'h001E;
   localparam logic [15:0] ADDR_LOOP_LO = 16'h003A;
   localparam logic [15:0] ADDR_LOOP_HI = 16'h003C;
   localparam logic [15:0] ADDR_FLAGS = 16'h0042;

   // Status register field positions
   localparam int BIT_ACC_A_OVF = 15;
   localparam int BIT_ACC_B_OVF = 14;
   localparam int BIT_ACC_A_CLIP = 13;
   localparam int BIT_ACC_B_CLIP = 12;
   localparam int BIT_EITHER_OVF = 11;
   localparam int BIT_EITHER_CLIP = 10;
   localparam int BIT_LOOP_ACTIVE = 9;
   localparam int BIT_HALF_CARRY = 8;
   localparam int BIT_PRIO_HI = 7;
   localparam int BIT_PRIO_LO = 5;
   localparam int BIT_REPEAT = 4;
   localparam int BIT_NEGATIVE = 3;
   localparam int BIT_SIGNED_WRAP = 2;
   localparam int BIT_ZERO = 1;
   localparam int BIT_CARRY = 0;

   // Carry vector taps for byte and word operations
   localparam int TAP_HALF_BYTE = 3;
   localparam int TAP_HALF_WORD = 7;
   localparam int TAP_MSB_BYTE = 7;
   localparam int TAP_MSB_WORD = 15;

   // Reset values
   localparam logic [15:0] FLAGS_RESET = 16'h0000;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [1:0] CTX_PRIMARY = 2'h0;
endpackage

// File: rtl/cscr_regs.sv
`timescale 1ns/1ps

module cscr_regs
   import cscr_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int LOOP_HI_W = 7
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Data-space access from instructions
   input wire logic [ADDR_W-1:0] mem_addr_i,
   input wire logic mem_rd_i,
   input wire logic mem_wr_i,
   input wire logic [DATA_W-1:0] mem_wdata_i,
   output logic [DATA_W-1:0] mem_rdata_o,
   output logic mem_hit_o,
   // Direct working register port of the core
   input wire logic [1:0] ctx_sel_i,
   input wire logic wreg_wr_i,
   input wire logic [3:0] wreg_waddr_i,
   input wire logic [DATA_W-1:0] wreg_wdata_i,
   input wire logic [3:0] wreg_raddr_i,
   output logic [DATA_W-1:0] wreg_rdata_o,
   // Loop start capture from the sequencer
   input wire logic loop_start_load_i,
   input wire logic [DATA_W+LOOP_HI_W-1:0] loop_start_addr_i,
   // Accumulator events
   input wire logic [1:0] acc_ovf_upd_i,
   input wire logic [1:0] acc_ovf_i,
   input wire logic [1:0] acc_sat_i,
   // ALU events
   input wire logic alu_nov_upd_i,
   input wire logic alu_neg_i,
   input wire logic alu_wrap_i,
   input wire logic alu_c_upd_i,
   input wire logic alu_dc_upd_i,
   input wire logic alu_byte_i,
   input wire logic [DATA_W-1:0] alu_carry_vec_i,
   input wire logic alu_z_upd_i,
   input wire logic alu_zero_i,
   input wire logic alu_z_sticky_i,
   // Loop state and interrupt control bits
   input wire logic loop_block_active_i,
   input wire logic repeat_running_i,
   input wire logic priority_level_msb_i,
   input wire logic nesting_disable_i,
   // Status outputs
   output logic [DATA_W-1:0] cpu_flags_register_o,
   output logic [3:0] cpu_ipl_o,
   output logic user_irq_dis_o
);

   // Refuse widths the address decode and loop registers cannot serve
   if (ADDR_W < 7 || ADDR_W > 16) begin : g_bad_addr
      $error("ADDR_W must lie between 7 and 16");
   end
   if (LOOP_HI_W < 1 || LOOP_HI_W > DATA_W) begin : g_bad_loop
      $error("LOOP_HI_W must lie between 1 and 16");
   end

   logic [DATA_W-1:0] wreg_mem [0:CTX_NUM-1][0:WREG_NUM-1];
   logic [DATA_W-1:0] flags_reg;
   logic [DATA_W-1:0] flags_next;
   logic [DATA_W-1:0] loop_lo_reg;
   logic [LOOP_HI_W-1:0] loop_hi_reg;
   logic [15:0] addr_w;
   logic sel_wreg;
   logic sel_flags;
   logic sel_loop_lo;
   logic sel_loop_hi;
   logic [3:0] mem_idx;
   logic [1:0] ctx_act;
   logic flags_wr;
   logic oab_clr;
   logic sab_clr;
   logic a_ovf_n;
   logic b_ovf_n;
   logic a_clip_n;
   logic b_clip_n;
   logic [DATA_W-1:0] rd_mux;

   // Widen the address to the decode width
   assign addr_w = 16'(mem_addr_i);

   // Address decoding, word aligned
   always_comb begin
      sel_wreg = 1'b0;
      sel_flags = 1'b0;
      sel_loop_lo = 1'b0;
      sel_loop_hi = 1'b0;
      if (addr_w <= ADDR_WREG_LAST) begin
         sel_wreg = 1'b1;
      end else if (addr_w == ADDR_FLAGS) begin
         sel_flags = 1'b1;
      end else if (addr_w == ADDR_LOOP_LO) begin
         sel_loop_lo = 1'b1;
      end else if (addr_w == ADDR_LOOP_HI) begin
         sel_loop_hi = 1'b1;
      end
   end

   assign mem_idx = 4'((addr_w - ADDR_WREG_BASE) >> 1);
   // Unknown context codes fall back to the primary array
   assign ctx_act = (ctx_sel_i < 2'(CTX_NUM)) ? ctx_sel_i : CTX_PRIMARY;
   assign flags_wr = mem_wr_i & sel_flags;

   // Working register banks; entry fifteen lives only in the primary bank
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int c = 0; c < CTX_NUM; c++) begin
            for (int e = 0; e < WREG_NUM; e++) begin
               wreg_mem[c][e] <= WORD_RESET;
            end
         end
      end else begin
         // Core port first so a mapped write in the same cycle lands last
         if (wreg_wr_i) begin
            if (wreg_waddr_i == WREG_STACK_IDX) begin
               wreg_mem[CTX_PRIMARY][WREG_STACK_IDX] <= wreg_wdata_i;
            end else begin
               wreg_mem[ctx_act][wreg_waddr_i] <= wreg_wdata_i;
            end
         end
         if (mem_wr_i && sel_wreg) begin
            if (mem_idx == WREG_STACK_IDX) begin
               wreg_mem[CTX_PRIMARY][WREG_STACK_IDX] <= mem_wdata_i;
            end else begin
               wreg_mem[ctx_act][mem_idx] <= mem_wdata_i;
            end
         end
      end
   end

   // Loop start registers are loaded by the sequencer only
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         loop_lo_reg <= WORD_RESET;
         loop_hi_reg <= '0;
      end else if (loop_start_load_i) begin
         // Instruction writes never reach here
         loop_lo_reg <= loop_start_addr_i[DATA_W-1:0];
         loop_hi_reg <= loop_start_addr_i[DATA_W+LOOP_HI_W-1:DATA_W];
      end
   end

   // Software clears of the combined flags act only on a bit that is set
   assign oab_clr = flags_wr & ~mem_wdata_i[BIT_EITHER_OVF] & flags_reg[BIT_EITHER_OVF];
   assign sab_clr = flags_wr & ~mem_wdata_i[BIT_EITHER_CLIP] & flags_reg[BIT_EITHER_CLIP];

   // Per-accumulator flags; hardware events override software in the same cycle
   always_comb begin
      a_ovf_n = flags_reg[BIT_ACC_A_OVF];
      b_ovf_n = flags_reg[BIT_ACC_B_OVF];
      if (flags_wr) begin
         a_ovf_n = mem_wdata_i[BIT_ACC_A_OVF] & ~oab_clr;
         b_ovf_n = mem_wdata_i[BIT_ACC_B_OVF] & ~oab_clr;
      end
      if (acc_ovf_upd_i[0]) begin
         a_ovf_n = acc_ovf_i[0];
      end
      if (acc_ovf_upd_i[1]) begin
         b_ovf_n = acc_ovf_i[1];
      end
      a_clip_n = flags_reg[BIT_ACC_A_CLIP];
      b_clip_n = flags_reg[BIT_ACC_B_CLIP];
      if (flags_wr) begin
         // Clearing the combined flag wipes both, else the word is taken
         a_clip_n = mem_wdata_i[BIT_ACC_A_CLIP] & ~sab_clr;
         b_clip_n = mem_wdata_i[BIT_ACC_B_CLIP] & ~sab_clr;
      end
      // Saturation sets win over any clear in the same cycle
      a_clip_n = a_clip_n | acc_sat_i[0];
      b_clip_n = b_clip_n | acc_sat_i[1];
   end

   // Next status word built from all sources
   always_comb begin
      flags_next = flags_reg;
      flags_next[BIT_ACC_A_OVF] = a_ovf_n;
      flags_next[BIT_ACC_B_OVF] = b_ovf_n;
      flags_next[BIT_ACC_A_CLIP] = a_clip_n;
      flags_next[BIT_ACC_B_CLIP] = b_clip_n;
      // Combined flags follow the new constituents, never a stale copy
      flags_next[BIT_EITHER_OVF] = a_ovf_n | b_ovf_n;
      flags_next[BIT_EITHER_CLIP] = a_clip_n | b_clip_n;
      // Loop state bits mirror the sequencer and ignore writes
      flags_next[BIT_LOOP_ACTIVE] = loop_block_active_i;
      flags_next[BIT_REPEAT] = repeat_running_i;
      // Writable ALU and priority bits
      if (flags_wr) begin
         flags_next[BIT_HALF_CARRY] = mem_wdata_i[BIT_HALF_CARRY];
         flags_next[BIT_NEGATIVE] = mem_wdata_i[BIT_NEGATIVE];
         flags_next[BIT_SIGNED_WRAP] = mem_wdata_i[BIT_SIGNED_WRAP];
         flags_next[BIT_ZERO] = mem_wdata_i[BIT_ZERO];
         flags_next[BIT_CARRY] = mem_wdata_i[BIT_CARRY];
         if (!nesting_disable_i) begin
            flags_next[BIT_PRIO_HI:BIT_PRIO_LO] =
               mem_wdata_i[BIT_PRIO_HI:BIT_PRIO_LO];
         end
      end
      // ALU results are the later effect and take priority over the write
      if (alu_dc_upd_i) begin
         flags_next[BIT_HALF_CARRY] = alu_byte_i ? alu_carry_vec_i[TAP_HALF_BYTE]
                                                 : alu_carry_vec_i[TAP_HALF_WORD];
      end
      if (alu_nov_upd_i) begin
         flags_next[BIT_NEGATIVE] = alu_neg_i;
         flags_next[BIT_SIGNED_WRAP] = alu_wrap_i;
      end
      if (alu_c_upd_i) begin
         flags_next[BIT_CARRY] = alu_byte_i ? alu_carry_vec_i[TAP_MSB_BYTE]
                                            : alu_carry_vec_i[TAP_MSB_WORD];
      end
      if (alu_z_upd_i) begin
         // Multi-precision ops keep Z on a zero result so a chain stays correct
         if (!alu_zero_i) begin
            flags_next[BIT_ZERO] = 1'b0;
         end else if (!alu_z_sticky_i) begin
            flags_next[BIT_ZERO] = 1'b1;
         end
      end
   end

   // Status register
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flags_reg <= FLAGS_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end
   assign cpu_flags_register_o = flags_reg;

   // Priority level and user interrupt gate
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cpu_ipl_o <= 4'h0;
         user_irq_dis_o <= 1'b0;
      end else begin
         cpu_ipl_o <= {priority_level_msb_i, flags_next[BIT_PRIO_HI:BIT_PRIO_LO]};
         user_irq_dis_o <= priority_level_msb_i;
      end
   end

   // Read data selection
   always_comb begin
      rd_mux = WORD_RESET;
      if (sel_wreg) begin
         if (mem_idx == WREG_STACK_IDX) begin
            rd_mux = wreg_mem[CTX_PRIMARY][WREG_STACK_IDX];
         end else begin
            rd_mux = wreg_mem[ctx_act][mem_idx];
         end
      end else if (sel_flags) begin
         rd_mux = flags_reg;
      end else if (sel_loop_lo) begin
         rd_mux = loop_lo_reg;
      end else if (sel_loop_hi) begin
         rd_mux = DATA_W'(loop_hi_reg);
      end
   end

   // Registered read answer, one cycle after the request
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mem_rdata_o <= WORD_RESET;
         mem_hit_o <= 1'b0;
      end else begin
         mem_hit_o <= (mem_rd_i | mem_wr_i) & (sel_wreg | sel_flags | sel_loop_lo | sel_loop_hi);
         if (mem_rd_i) begin
            mem_rdata_o <= rd_mux;
         end
      end
   end

   // Core read port of the active context
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wreg_rdata_o <= WORD_RESET;
      end else if (wreg_raddr_i == WREG_STACK_IDX) begin
         wreg_rdata_o <= wreg_mem[CTX_PRIMARY][WREG_STACK_IDX];
      end else begin
         wreg_rdata_o <= wreg_mem[ctx_act][wreg_raddr_i];
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   chk_a_ovf_set: assert property (acc_ovf_upd_i[0] && acc_ovf_i[0] |=>
      flags_reg[BIT_ACC_A_OVF] && flags_reg[BIT_EITHER_OVF])
      else $error("accumulator A overflow not flagged");
   chk_b_ovf_set: assert property (acc_ovf_upd_i[1] && acc_ovf_i[1] |=>
      flags_reg[BIT_ACC_B_OVF] && flags_reg[BIT_EITHER_OVF])
      else $error("accumulator B overflow not flagged");
   chk_a_clip_hold: assert property (flags_reg[BIT_ACC_A_CLIP] && !flags_wr |=>
      flags_reg[BIT_ACC_A_CLIP])
      else $error("accumulator A sticky flag dropped");
   chk_b_clip_set: assert property (acc_sat_i[1] |=> flags_reg[BIT_ACC_B_CLIP][*2]
      or (flags_reg[BIT_ACC_B_CLIP] ##1 $past(flags_wr)))
      else $error("accumulator B sticky flag not held");
   chk_either_ovf: assert property (flags_reg[BIT_EITHER_OVF] ==
      (flags_reg[BIT_ACC_A_OVF] | flags_reg[BIT_ACC_B_OVF]))
      else $error("combined overflow flag mismatch");
   chk_either_clip: assert property (flags_reg[BIT_EITHER_CLIP] ==
      (flags_reg[BIT_ACC_A_CLIP] | flags_reg[BIT_ACC_B_CLIP]))
      else $error("combined sticky flag mismatch");
   chk_clip_wipe: assert property (sab_clr && acc_sat_i == 2'h0 |=>
      !flags_reg[BIT_ACC_A_CLIP] && !flags_reg[BIT_ACC_B_CLIP])
      else $error("clearing combined sticky flag left a flag set");
   chk_prio_locked: assert property (nesting_disable_i && flags_wr |=>
      $stable(flags_reg[BIT_PRIO_HI:BIT_PRIO_LO]))
      else $error("priority field changed while nesting disabled");
   chk_loop_ro: assert property (mem_wr_i && (sel_loop_lo || sel_loop_hi) &&
      !loop_start_load_i |=> $stable(loop_lo_reg) && $stable(loop_hi_reg))
      else $error("loop start register changed by a data write");
   chk_half_byte: assert property (alu_dc_upd_i && alu_byte_i |=>
      flags_reg[BIT_HALF_CARRY] == $past(alu_carry_vec_i[TAP_HALF_BYTE]))
      else $error("half carry taken from the wrong bit");
   chk_irq_gate: assert property (priority_level_msb_i |=> user_irq_dis_o && cpu_ipl_o[3])
      else $error("user interrupts not disabled by priority MSB");
   chk_loop_flag: assert property (##1 flags_reg[BIT_LOOP_ACTIVE] ==
      $past(loop_block_active_i))
      else $error("loop active flag does not follow the sequencer");

endmodule

// File: testbench/cscr_regs_bench.sv
`timescale 1ns/1ps

module cscr_regs_bench;
   import cscr_pkg::*;
   // Clock, reset and data-space drive
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [15:0] mem_addr_i = 16'h0000;
   logic mem_rd_i = 1'b0;
   logic mem_wr_i = 1'b0;
   logic [15:0] mem_wdata_i = 16'h0000;
   // Core side drive
   logic [1:0] ctx_sel_i = 2'h0;
   logic wreg_wr_i = 1'b0;
   logic [3:0] wreg_waddr_i = 4'h0;
   logic [15:0] wreg_wdata_i = 16'h0000;
   logic [3:0] wreg_raddr_i = 4'h0;
   logic loop_start_load_i = 1'b0;
   logic [22:0] loop_start_addr_i = 23'h000000;
   // Event pulses packed in one vector, carry vector and levels
   logic [14:0] ev = 15'h0000;
   logic [15:0] cv = 16'h0000;
   logic lvl_loop = 1'b0;
   logic lvl_rep = 1'b0;
   logic lvl_msb = 1'b0;
   logic lvl_nd = 1'b0;
   // Outputs
   logic [15:0] mem_rdata_o;
   logic mem_hit_o;
   logic [15:0] wreg_rdata_o;
   logic [15:0] cpu_flags_register_o;
   logic [3:0] cpu_ipl_o;
   logic user_irq_dis_o;
   // Expected read results, oldest first, as {hit, data}
   logic [16:0] exp_q[$];
   logic [16:0] note;
   logic rd_q = 1'b0;
   logic [15:0] wm [0:2][0:15];
   logic [15:0] v;
   logic b;
   int err_count = 0;
   int n_checks = 0;

   cscr_regs dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .mem_addr_i(mem_addr_i), .mem_rd_i(mem_rd_i),
      .mem_wr_i(mem_wr_i), .mem_wdata_i(mem_wdata_i), .mem_rdata_o(mem_rdata_o),
      .mem_hit_o(mem_hit_o), .ctx_sel_i(ctx_sel_i), .wreg_wr_i(wreg_wr_i),
      .wreg_waddr_i(wreg_waddr_i), .wreg_wdata_i(wreg_wdata_i), .wreg_raddr_i(wreg_raddr_i),
      .wreg_rdata_o(wreg_rdata_o), .loop_start_load_i(loop_start_load_i),
      .loop_start_addr_i(loop_start_addr_i), .acc_ovf_upd_i(ev[1:0]), .acc_ovf_i(ev[3:2]),
      .acc_sat_i(ev[5:4]), .alu_nov_upd_i(ev[6]), .alu_neg_i(ev[7]), .alu_wrap_i(ev[8]),
      .alu_c_upd_i(ev[9]), .alu_dc_upd_i(ev[10]), .alu_byte_i(ev[11]), .alu_carry_vec_i(cv),
      .alu_z_upd_i(ev[12]), .alu_zero_i(ev[13]), .alu_z_sticky_i(ev[14]),
      .loop_block_active_i(lvl_loop), .repeat_running_i(lvl_rep),
      .priority_level_msb_i(lvl_msb), .nesting_disable_i(lvl_nd),
      .cpu_flags_register_o(cpu_flags_register_o), .cpu_ipl_o(cpu_ipl_o),
      .user_irq_dis_o(user_irq_dis_o)
   );

   // 250 MHz clock
   always #2 clk_i = ~clk_i;

   task automatic fail(input string msg);
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string msg);
      n_checks++;
      if (got !== exp) fail(msg);
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_i);
      mem_addr_i <= a;
      mem_wdata_i <= d;
      mem_wr_i <= 1'b1;
      @(posedge clk_i);
      mem_wr_i <= 1'b0;
   endtask

   // Notes the expected answer, then issues a one-cycle read
   task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic hit = 1'b1);
      @(posedge clk_i);
      exp_q.push_back({hit, exp});
      mem_addr_i <= a;
      mem_rd_i <= 1'b1;
      @(posedge clk_i);
      mem_rd_i <= 1'b0;
   endtask

   task automatic rs(input logic [15:0] exp);
      rd(ADDR_FLAGS, exp);
   endtask

   task automatic pulse(input logic [14:0] e, input logic [15:0] c);
      @(posedge clk_i);
      ev <= e;
      cv <= c;
      @(posedge clk_i);
      ev <= 15'h0000;
   endtask

   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Read answers land exactly one cycle after the sampling edge
   always @(posedge clk_i) begin
      rd_q <= mem_rd_i;
      if (rd_q === 1'b1) begin
         if (exp_q.size() == 0) begin
            fail("read answer with no note");
         end else begin
            note = exp_q.pop_front();
            n_checks++;
            if ({mem_hit_o, mem_rdata_o} !== note) fail("read data or hit differs");
         end
      end
   end

   // Hang guard well above the run length
   initial begin
      #200000;
      fail("run limit reached");
      wrap_up();
   end

   initial begin
      void'($urandom(32'h3f56));
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      rs(16'h0000);
      rd(ADDR_LOOP_LO, 16'h0000);
      // Overflow flags and their combined flag
      pulse(15'h0005, 16'h0000);
      rs(16'h8800);
      pulse(15'h000A, 16'h0000);
      rs(16'hC800);
      pulse(15'h0001, 16'h0000);
      rs(16'h4800);
      wr(ADDR_FLAGS, 16'h4000);
      rs(16'h0000);
      wr(ADDR_FLAGS, 16'h0800);
      rs(16'h0000);
      wr(ADDR_FLAGS, 16'h8000);
      rs(16'h8800);
      pulse(15'h0001, 16'h0000);
      rs(16'h0000);
      // Sticky saturation flags
      pulse(15'h0010, 16'h0000);
      rs(16'h2400);
      repeat (4) @(posedge clk_i);
      rs(16'h2400);
      pulse(15'h0020, 16'h0000);
      rs(16'h3400);
      wr(ADDR_FLAGS, 16'h3000);
      rs(16'h0000);
      pulse(15'h0010, 16'h0000);
      wr(ADDR_FLAGS, 16'h1400);
      rs(16'h1400);
      wr(ADDR_FLAGS, 16'h0400);
      rs(16'h0000);
      // Loop state bits follow their levels and ignore writes
      @(posedge clk_i);
      lvl_loop <= 1'b1;
      lvl_rep <= 1'b1;
      wr(ADDR_FLAGS, 16'h0000);
      rs(16'h0210);
      lvl_loop <= 1'b0;
      lvl_rep <= 1'b0;
      wr(ADDR_FLAGS, 16'h0210);
      rs(16'h0000);
      // Negative, signed wrap and sticky zero
      pulse(15'h00C0, 16'h0000);
      rs(16'h0008);
      pulse(15'h0140, 16'h0000);
      rs(16'h0004);
      // Clear negative and signed wrap so later words hold only the bits under test
      pulse(15'h0040, 16'h0000);
      pulse(15'h3000, 16'h0000);
      rs(16'h0002);
      pulse(15'h7000, 16'h0000);
      rs(16'h0002);
      pulse(15'h1000, 16'h0000);
      rs(16'h0000);
      pulse(15'h7000, 16'h0000);
      rs(16'h0000);
      // Half carry and carry taps for byte and word sizes
      for (int k = 0; k < 12; k++) begin
         v = 16'($urandom);
         b = 1'($urandom);
         pulse(15'h0600 | {3'h0, b, 11'h000}, v);
         rs({7'h00, b ? v[3] : v[7], 7'h00, b ? v[7] : v[15]});
      end
      // Priority field, its extension bit and nesting lock
      wr(ADDR_FLAGS, 16'h00E0);
      rs(16'h00E0);
      lvl_msb <= 1'b1;
      settle();
      cmp({12'h000, cpu_ipl_o}, 16'h000F, "priority level");
      cmp({15'h0000, user_irq_dis_o}, 16'h0001, "user interrupts not off");
      lvl_nd <= 1'b1;
      wr(ADDR_FLAGS, 16'h0040);
      rs(16'h00E0);
      lvl_nd <= 1'b0;
      wr(ADDR_FLAGS, 16'h0040);
      rs(16'h0040);
      settle();
      cmp({12'h000, cpu_ipl_o}, 16'h000A, "priority level");
      lvl_msb <= 1'b0;
      settle();
      cmp({12'h000, cpu_ipl_o}, 16'h0002, "priority level");
      cmp({15'h0000, user_irq_dis_o}, 16'h0000, "user interrupts off");
      // Three contexts; the stack entry is shared with the primary set
      for (int c = 0; c < 3; c++) begin
         ctx_sel_i <= 2'(c);
         for (int i = 0; i < 16; i++) begin
            v = 16'($urandom);
            if (i == 15) wm[0][15] = v;
            else wm[c][i] = v;
            wr(16'(2 * i), v);
         end
      end
      for (int c = 0; c < 3; c++) begin
         ctx_sel_i <= 2'(c);
         for (int i = 0; i < 16; i++) begin
            rd(16'(2 * i), (i == 15) ? wm[0][15] : wm[c][i]);
         end
      end
      // The unused context code falls back to the primary set
      ctx_sel_i <= 2'h3;
      rd(16'h0004, wm[0][2]);
      // Core port write seen through the mapped copy of the active set
      @(posedge clk_i);
      ctx_sel_i <= 2'h1;
      wreg_wr_i <= 1'b1;
      wreg_waddr_i <= 4'h3;
      wreg_wdata_i <= 16'hC3A5;
      wreg_raddr_i <= 4'h3;
      @(posedge clk_i);
      wreg_wr_i <= 1'b0;
      rd(16'h0006, 16'hC3A5);
      cmp(wreg_rdata_o, 16'hC3A5, "core read port");
      // Loop start registers load from the sequencer only
      @(posedge clk_i);
      loop_start_load_i <= 1'b1;
      loop_start_addr_i <= 23'h7FABCD;
      @(posedge clk_i);
      loop_start_load_i <= 1'b0;
      wr(ADDR_LOOP_LO, 16'h1234);
      wr(ADDR_LOOP_HI, 16'h0001);
      rd(ADDR_LOOP_LO, 16'hABCD);
      rd(ADDR_LOOP_HI, 16'h007F);
      // Unmapped place answers zero without a hit
      wr(16'h0100, 16'hFFFF);
      rd(16'h0100, 16'h0000, 1'b0);
      // Reset in mid-run clears the status word
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      settle();
      cmp(cpu_flags_register_o, 16'h0000, "status after reset");
      @(posedge clk_i);
      arst_n_i <= 1'b1;
      rs(16'h0000);
      for (int k = 0; k < 10 && exp_q.size() > 0; k++) @(posedge clk_i);
      if (exp_q.size() > 0) fail("read answers missing");
      wrap_up();
   end
endmodule
